// *** hw/ptp_msg_cfg_consts.vh ***
// constants for the ptp message configuration block
// assumes an apb master with 32-bit data on the switch core clock
`ifndef PTP_MSG_CFG_CONSTS_VH
`define PTP_MSG_CFG_CONSTS_VH
// register indices; byte address is four times the index
`define IDX_CFG_FIRST   14'h0514
`define IDX_CFG_SECOND  14'h0516
`define IDX_DOMAIN      14'h0518
`define IDX_STATUS      14'h051c
`define CFG_FIRST_RST   16'h0039
`define CFG_SECOND_RST  16'h1004
`define CFG_FIRST_WMSK  16'h00ff
`define CFG_SECOND_WMSK 16'h1fff
`define DOMAIN_RST      8'h00
// first config fields
`define B_AS_EN     7
`define B_PTP_EN    6
`define B_RAW_EN    5
`define B_V4_EN     4
`define B_V6_EN     3
`define B_P2P       2
`define B_MASTER    1
`define B_ONE_STEP  0
// second config fields
`define B_UNICAST   12
`define B_ALT_MST   11
`define B_ALL_PRIO  10
`define B_CHK_SYNC  9
`define B_CHK_DLY   8
`define B_CHK_PDLY  7
`define B_CHK_DOM   4
// encapsulations
`define ENC_RAW     2'h0
`define ENC_V4      2'h1
`define ENC_V6      2'h2
// message types
`define MT_SYNC     4'h0
`define MT_DREQ     4'h1
`define MT_PDREQ    4'h2
`define MT_PDRESP   4'h3
`define MT_FUP      4'h8
`define MT_DRESP    4'h9
`define MT_PDFUP    4'ha
`define B_MT_GENERAL 3
`define UDP_EVENT   16'h013f
`define UDP_GENERAL 16'h0140
// identity store slots
`define SLOT_SYNC   2'h0
`define SLOT_DREQ   2'h1
`define SLOT_PDREQ  2'h2
`define KEY_W       104
`endif

// *** hw/ptp_msg_cfg.v ***
// ptp message configuration registers and per-message classifier
// assumes messages arrive already parsed, one per cycle, synchronous to pclk
`timescale 1ns/1ns
`include "ptp_msg_cfg_consts.vh"
module ptp_msg_cfg
(
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [15:0]  paddr,
  input  wire [31:0]  pwdata,
  input  wire [3:0]   pstrb,
  output wire [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  input  wire         msg_valid,
  input  wire [3:0]   msg_type,
  input  wire [1:0]   msg_encap,
  input  wire         msg_multicast,
  input  wire [15:0]  msg_udp_port,
  input  wire [7:0]   msg_domain,
  input  wire [15:0]  msg_seq_id,
  input  wire [79:0]  msg_src_port,
  input  wire         msg_from_host,
  input  wire         msg_from_master,
  output wire         mode_as_en,
  output wire         mode_ptp_en,
  output wire         mode_p2p,
  output wire         mode_master,
  output wire         mode_one_step,
  output wire         dec_valid,
  output wire         dec_is_ptp,
  output wire         dec_unicast,
  output wire         dec_to_host,
  output wire         dec_to_nonhost,
  output wire         dec_high_prio
);

////////////////////////////////////////////////////////////////////////////
// helpers

function [13:0] word_index;
  input [15:0] addr;
  begin
    word_index = addr[15:2];
  end
endfunction

function [15:0] apply_strb;
  input [15:0] old_val;
  input [15:0] new_val;
  input [1:0]  strb;
  input [15:0] wmask;
  reg   [15:0] lane;
  begin
    lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    apply_strb = (old_val & ~lane) | (new_val & lane);
  end
endfunction

function key_match;
  input               vld;
  input [`KEY_W-1:0]  stored;
  input [`KEY_W-1:0]  cur;
  begin
    key_match = vld & (stored == cur);
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// registers

reg  [15:0]         cfg1_ff;
reg  [15:0]         cfg2_ff;
reg  [7:0]          domain_ff;
reg  [31:0]         prdata_ff;
reg                 pready_ff;
reg                 pslverr_ff;
reg  [`KEY_W-1:0]   seen_ff [0:2];
reg  [2:0]          seen_vld_ff;
reg                 dec_valid_ff;
reg                 dec_is_ptp_ff;
reg                 dec_unicast_ff;
reg                 dec_to_host_ff;
reg                 dec_to_nonhost_ff;
reg                 dec_high_prio_ff;
reg  [7:0]          ptp_cnt_ff;

wire                acc;
wire                wr_en;
wire [13:0]         idx;
wire                hit;
reg  [31:0]         nxt_prdata;

////////////////////////////////////////////////////////////////////////////
// apb slave: pready rises on the second access cycle

assign idx   = word_index(paddr);
assign acc   = psel & penable;
assign wr_en = acc & pready_ff & pwrite & ~pslverr_ff;
assign hit   = (idx == `IDX_CFG_FIRST) | (idx == `IDX_CFG_SECOND) |
               (idx == `IDX_DOMAIN) | (idx == `IDX_STATUS);

always @*
begin
  case (idx)
    `IDX_CFG_FIRST:  nxt_prdata = {16'h0000, cfg1_ff};
    `IDX_CFG_SECOND: nxt_prdata = {16'h0000, cfg2_ff};
    `IDX_DOMAIN:     nxt_prdata = {24'h000000, domain_ff};
    `IDX_STATUS:     nxt_prdata = {21'h000000, seen_vld_ff, ptp_cnt_ff};
    default:         nxt_prdata = 32'h00000000;
  endcase
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pready_ff  <= 1'b0;
    pslverr_ff <= 1'b0;
    prdata_ff  <= 32'h00000000;
  end
  else
  begin
    // one wait state keeps prdata a clean flop output
    pready_ff  <= acc & ~pready_ff;
    pslverr_ff <= acc & ~pready_ff & ~hit;
    // status register is read-only; writing it is an error
    if (acc & ~pready_ff & pwrite & (idx == `IDX_STATUS))
      pslverr_ff <= 1'b1;
    if (acc & ~pready_ff & ~pwrite)
      prdata_ff <= nxt_prdata;
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    cfg1_ff   <= `CFG_FIRST_RST;
    cfg2_ff   <= `CFG_SECOND_RST;
    domain_ff <= `DOMAIN_RST;
  end
  else if (wr_en)
  begin
    // reserved bits are masked and never take a write
    if (idx == `IDX_CFG_FIRST)
      cfg1_ff <= apply_strb(cfg1_ff, pwdata[15:0], pstrb[1:0],
                            `CFG_FIRST_WMSK);
    if (idx == `IDX_CFG_SECOND)
      cfg2_ff <= apply_strb(cfg2_ff, pwdata[15:0], pstrb[1:0],
                            `CFG_SECOND_WMSK);
    if ((idx == `IDX_DOMAIN) && pstrb[0])
      domain_ff <= pwdata[7:0];
  end
end

assign prdata  = prdata_ff;
assign pready  = pready_ff;
assign pslverr = pslverr_ff;

assign mode_as_en    = cfg1_ff[`B_AS_EN];
assign mode_ptp_en   = cfg1_ff[`B_PTP_EN];
assign mode_p2p      = cfg1_ff[`B_P2P];
assign mode_master   = cfg1_ff[`B_MASTER];
assign mode_one_step = cfg1_ff[`B_ONE_STEP];

////////////////////////////////////////////////////////////////////////////
// classifier

wire                any_en;
wire                enc_ok;
wire                uc_port;
wire                uc;
wire                is_ptp;
wire                same_dom;
wire                dom_ok;
wire [`KEY_W-1:0]   key;
wire                sd_master;
wire                suppress;
reg                 assoc_ok;
reg                 store_en;
reg  [1:0]          store_slot;
wire                nxt_to_host;
wire                nxt_to_nonhost;
wire                nxt_high_prio;

assign any_en  = cfg1_ff[`B_AS_EN] | cfg1_ff[`B_PTP_EN];
assign enc_ok  = ((msg_encap == `ENC_RAW) & cfg1_ff[`B_RAW_EN]) |
                 ((msg_encap == `ENC_V4) & cfg1_ff[`B_V4_EN]) |
                 ((msg_encap == `ENC_V6) & cfg1_ff[`B_V6_EN]);
assign uc_port = (msg_udp_port == `UDP_EVENT) |
                 (msg_udp_port == `UDP_GENERAL);
// raw frames carry no udp port, so they are only ever multicast
assign uc      = ~msg_multicast & cfg2_ff[`B_UNICAST] &
                 (msg_encap != `ENC_RAW) & uc_port;
assign is_ptp  = any_en & enc_ok & (msg_multicast | uc);
assign same_dom = (msg_domain == domain_ff);
assign dom_ok  = ~cfg2_ff[`B_CHK_DOM] | same_dom;
assign key     = {msg_domain, msg_seq_id, msg_src_port};
assign sd_master = ((msg_type == `MT_SYNC) | (msg_type == `MT_DREQ)) &
                   msg_from_master & ~msg_from_host;
// same-domain master traffic the host must not see again
assign suppress  = sd_master & same_dom & ~cfg2_ff[`B_ALT_MST];

always @*
begin
  assoc_ok   = 1'b1;
  store_en   = 1'b0;
  store_slot = `SLOT_SYNC;
  case (msg_type)
    `MT_SYNC:
    begin
      store_en   = 1'b1;
      store_slot = `SLOT_SYNC;
    end
    `MT_DREQ:
    begin
      store_en   = 1'b1;
      store_slot = `SLOT_DREQ;
    end
    `MT_PDREQ:
    begin
      store_en   = 1'b1;
      store_slot = `SLOT_PDREQ;
    end
    `MT_FUP:
      assoc_ok = ~cfg2_ff[`B_CHK_SYNC] |
                 key_match(seen_vld_ff[`SLOT_SYNC],
                           seen_ff[`SLOT_SYNC], key);
    `MT_DRESP:
      assoc_ok = ~cfg2_ff[`B_CHK_DLY] |
                 key_match(seen_vld_ff[`SLOT_DREQ],
                           seen_ff[`SLOT_DREQ], key);
    `MT_PDRESP, `MT_PDFUP:
      assoc_ok = ~cfg2_ff[`B_CHK_PDLY] |
                 key_match(seen_vld_ff[`SLOT_PDREQ],
                           seen_ff[`SLOT_PDREQ], key);
    default:
      assoc_ok = 1'b1;
  endcase
end

// unicast frames bypass ptp steering and follow the lookup table
assign nxt_to_host = is_ptp & ~uc & ~msg_from_host & dom_ok & assoc_ok &
                     ~suppress;
assign nxt_to_nonhost = ~is_ptp | uc | ~suppress;
assign nxt_high_prio = is_ptp &
                       (cfg2_ff[`B_ALL_PRIO] | ~msg_type[`B_MT_GENERAL]);

////////////////////////////////////////////////////////////////////////////
// identity store for response matching

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    seen_vld_ff <= 3'h0;
    seen_ff[0]  <= {`KEY_W{1'b0}};
    seen_ff[1]  <= {`KEY_W{1'b0}};
    seen_ff[2]  <= {`KEY_W{1'b0}};
  end
  else if (msg_valid & is_ptp & store_en)
  begin
    // only the latest request is kept; older pending ones are lost
    seen_ff[store_slot]     <= key;
    seen_vld_ff[store_slot] <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////
// decision outputs, one cycle after the message

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    dec_valid_ff      <= 1'b0;
    dec_is_ptp_ff     <= 1'b0;
    dec_unicast_ff    <= 1'b0;
    dec_to_host_ff    <= 1'b0;
    dec_to_nonhost_ff <= 1'b0;
    dec_high_prio_ff  <= 1'b0;
    ptp_cnt_ff        <= 8'h00;
  end
  else
  begin
    dec_valid_ff      <= msg_valid;
    dec_is_ptp_ff     <= msg_valid & is_ptp;
    dec_unicast_ff    <= msg_valid & is_ptp & uc;
    dec_to_host_ff    <= msg_valid & nxt_to_host;
    dec_to_nonhost_ff <= msg_valid & nxt_to_nonhost;
    dec_high_prio_ff  <= msg_valid & nxt_high_prio;
    // status count wraps; software reads differences
    if (msg_valid & is_ptp)
      ptp_cnt_ff <= ptp_cnt_ff + 8'h01;
  end
end

assign dec_valid      = dec_valid_ff;
assign dec_is_ptp     = dec_is_ptp_ff;
assign dec_unicast    = dec_unicast_ff;
assign dec_to_host    = dec_to_host_ff;
assign dec_to_nonhost = dec_to_nonhost_ff;
assign dec_high_prio  = dec_high_prio_ff;

endmodule // ptp_msg_cfg

// *** test/ptp_msg_cfg_monitor.sv ***
// port checker for the ptp message configuration block
// assumes the apb and message timing of the design hand-over
`timescale 1ns/1ns
`include "ptp_msg_cfg_consts.vh"
module ptp_msg_cfg_monitor
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire        msg_valid,
  input wire [3:0]  msg_type,
  input wire        msg_multicast,
  input wire [15:0] msg_udp_port,
  input wire        msg_from_host,
  input wire        mode_as_en,
  input wire        mode_ptp_en,
  input wire        mode_p2p,
  input wire        mode_master,
  input wire        mode_one_step,
  input wire        dec_valid,
  input wire        dec_is_ptp,
  input wire        dec_unicast,
  input wire        dec_to_host,
  input wire        dec_to_nonhost,
  input wire        dec_high_prio
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  apb_answer_a: assert property (psel && !penable |-> ##2 pready)
    else $error("apb answer not two cycles after setup");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  cfg_write_a: assert property (psel && penable && pready && pwrite
    && paddr == {`IDX_CFG_FIRST, 2'b00} && pstrb[0] |=> {mode_as_en,
    mode_ptp_en, mode_p2p, mode_master, mode_one_step}
    == {$past(pwdata[7:6]), $past(pwdata[2:0])})
    else $error("mode outputs do not follow write");
  dec_time_a: assert property (msg_valid |=> dec_valid)
    else $error("decision not one cycle after message");
  dec_idle_a: assert property (!dec_valid |-> !(dec_is_ptp | dec_unicast
    | dec_to_host | dec_to_nonhost | dec_high_prio))
    else $error("decision bits without valid");
  uni_port_a: assert property (dec_unicast |-> dec_is_ptp && !dec_to_host
    && ($past(msg_udp_port) == 16'h013f || $past(msg_udp_port) == 16'h0140))
    else $error("unicast with wrong port or to host");
  host_mc_a: assert property (dec_to_host |-> $past(msg_multicast)
    && !$past(msg_from_host))
    else $error("host forward of unicast or host frame");
  event_prio_a: assert property (dec_is_ptp && !$past(msg_type[3])
    |-> dec_high_prio)
    else $error("event message not high priority");
  cover property (dec_to_host);
  cover property (dec_unicast);
  cover property (pready && pslverr);
endmodule // ptp_msg_cfg_monitor
bind ptp_msg_cfg ptp_msg_cfg_monitor i_mon (.*);

// *** test/ptp_peer.sv ***
// model of the ptp peers that feed parsed messages
// assumes the bench calls send once per message
`timescale 1ns/1ns
module ptp_peer
(
  input  wire        pclk,
  output reg         msg_valid,
  output reg  [3:0]  msg_type,
  output reg  [1:0]  msg_encap,
  output reg         msg_multicast,
  output reg  [15:0] msg_udp_port,
  output reg  [7:0]  msg_domain,
  output reg  [15:0] msg_seq_id,
  output reg  [79:0] msg_src_port,
  output reg         msg_from_host,
  output reg         msg_from_master
);
  initial {msg_valid, msg_type, msg_encap, msg_multicast, msg_udp_port,
    msg_domain, msg_seq_id, msg_src_port, msg_from_host,
    msg_from_master} = 0;
  task send(input [3:0] t, input [1:0] e, input mc, input [15:0] p,
    input [7:0] d, input [15:0] s, input hst, input mst);
    @(posedge pclk);
    {msg_valid, msg_type, msg_encap, msg_multicast} <= {1'b1, t, e, mc};
    {msg_udp_port, msg_domain, msg_seq_id} <= {p, d, s};
    msg_src_port <= 80'h0123_4567_89ab_cdef_0011;
    {msg_from_host, msg_from_master} <= {hst, mst};
    @(posedge pclk);
    // type, domain and sequence id flip when idle so a held value is never mistaken for data
    msg_valid <= 1'b0;
    {msg_type, msg_domain, msg_seq_id} <= ~{t, d, s};
  endtask
endmodule // ptp_peer

// *** test/testbench.sv ***
// bench for the ptp message configuration block
// assumes registers at four times their index, peer model on messages
`timescale 1ns/1ns
`include "ptp_msg_cfg_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  reg          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [15:0]  paddr = 0;
  reg  [31:0]  pwdata = 0, rd;
  reg  [3:0]   pstrb = 0;
  reg          er;
  wire [31:0]  prdata;
  wire         pready, pslverr, msg_valid, msg_multicast, msg_from_host;
  wire         msg_from_master, mode_as_en, mode_ptp_en, mode_p2p;
  wire         mode_master, mode_one_step, dec_valid, dec_is_ptp;
  wire         dec_unicast, dec_to_host, dec_to_nonhost, dec_high_prio;
  wire [3:0]   msg_type;
  wire [1:0]   msg_encap;
  wire [15:0]  msg_udp_port, msg_seq_id;
  wire [7:0]   msg_domain;
  wire [79:0]  msg_src_port;
  integer      err_total = 0, checked = 0, cyc = 0, i;
  localparam [15:0] A1 = {`IDX_CFG_FIRST, 2'b00};
  localparam [15:0] A2 = {`IDX_CFG_SECOND, 2'b00};
  ptp_msg_cfg i_ptp_msg_cfg (.*);
  ptp_peer    i_ptp_peer (.*);
  always #20 pclk = ~pclk;
  ////////////////////////////////////////
  task end_sim;
    $display("mismatches %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded by the watchdog below, which fails the run at cycle 5000
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      end_sim;
    end
  end
  task apb(input w, input [15:0] a, input [15:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr} <= {2'b10, w, a};
    {pwdata, pstrb} <= {16'h0000, d, 4'hf};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task m(input [3:0] t, input [1:0] e, input mc, input [15:0] p,
    input [7:0] d, input [15:0] s, input mst, input [4:0] ex, mk);
    i_ptp_peer.send(t, e, mc, p, d, s, 1'b0, mst);
    @(posedge pclk);
    `CHK({dec_valid, {dec_is_ptp, dec_unicast, dec_to_host,
      dec_to_nonhost, dec_high_prio} & mk}, {1'b1, ex})
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A1, 0); `CHK(rd, 32'h0039)
    apb(0, A2, 0); `CHK(rd, 32'h1004)
    apb(1, A1, 16'hffff); apb(0, A1, 0); `CHK(rd, 32'h00ff)
    `CHK({mode_as_en, mode_ptp_en, mode_p2p, mode_master, mode_one_step}, 5'h1f)
    apb(0, 16'h1454, 0); `CHK(er, 1'b1)
    apb(1, A1, 16'h0078); apb(1, A2, 16'h1004);
    m(4'h0, 2'h0, 1, 16'h0, 8'h0, 1, 0, 5'b10101, 5'b11101);
    m(4'h8, 2'h0, 1, 16'h0, 8'h0, 1, 0, 5'b10100, 5'b11101);
    apb(1, A2, 16'h1404);
    m(4'h8, 2'h0, 1, 16'h0, 8'h0, 1, 0, 5'b10101, 5'b11101);
    m(4'h0, 2'h1, 0, 16'd319, 8'h0, 1, 0, 5'b11010, 5'b11110);
    m(4'h8, 2'h2, 0, 16'd320, 8'h0, 1, 0, 5'b11010, 5'b11110);
    apb(1, A2, 16'h0404);
    m(4'h0, 2'h1, 0, 16'd319, 8'h0, 1, 0, 5'b00010, 5'b11110);
    apb(1, A1, 16'h0068);
    m(4'h0, 2'h1, 1, 16'd319, 8'h0, 1, 0, 5'b00000, 5'b10000);
    apb(1, A1, 16'h0078);
    for (i = 0; i < 3; i++)
    begin
      apb(1, A2, 16'h0004 | (16'h0200 >> i));
      m(i[3:0], 2'h0, 1, 16'h0, 8'h0, 5, 0, 5'b00000, 5'b00000);
      m(12'h398 >> (4 * i), 2'h0, 1, 16'h0, 8'h0, 5, 0, 5'b00100, 5'b00100);
      m(12'h398 >> (4 * i), 2'h0, 1, 16'h0, 8'h0, 6, 0, 5'b00000, 5'b00100);
    end
    apb(1, A2, 16'h0004);
    m(4'h0, 2'h0, 1, 16'h0, 8'h0, 1, 1, 5'b00000, 5'b00110);
    m(4'h0, 2'h0, 1, 16'h0, 8'h3, 1, 1, 5'b00010, 5'b00010);
    apb(1, A2, 16'h0804);
    m(4'h1, 2'h0, 1, 16'h0, 8'h0, 1, 1, 5'b00010, 5'b00010);
    m(4'h0, 2'h0, 1, 16'h0, 8'h0, 1, 1, 5'b00110, 5'b00110);
    apb(1, 16'h1460, 16'h0003); apb(0, 16'h1460, 0);
    `CHK(rd, 32'h0003)
    apb(1, A2, 16'h0814);
    m(4'h0, 2'h0, 1, 16'h0, 8'h3, 1, 0, 5'b10100, 5'b10100);
    m(4'h0, 2'h0, 1, 16'h0, 8'h4, 1, 0, 5'b10000, 5'b10100);
    apb(0, 16'h1470, 0); `CHK(rd[10:8], 3'h7)
    apb(1, 16'h1470, 16'h0000); `CHK(er, 1'b1)
    end_sim;
  end
endmodule // testbench
